// ===== scda_array.sv
// scda_array: register array with OTP shadow, writable block, init lock and CRC checks.
// assumes requests come from a frame decoder on clk_i and OTP fuses are stable after reset.
`timescale 1ns/1ps
`default_nettype none

module scda_array
  import scda_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register requests from the frame decoder
  input  wire logic       req_i,
  input  wire scda_req_s  req_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_invalid_o,
  // factory fuses and live status
  input  wire scda_otp_s  otp_i,
  input  wire scda_stat_s stat_i,
  // configuration and health
  output scda_cfg_s       cfg_o,
  output logic            init_done_lock_o,
  output logic            otp_crc_err_o,
  output logic            wr_crc_err_o,
  output logic            soft_reset_o
);

  function automatic logic [7:0] scda_crc8(input logic [63:0] data);
    logic [7:0] crc;
    crc = SCDA_CRC_SEED;
    for (int i = 63; i >= 0; i--) begin
      if (crc[7] ^ data[i]) begin
        crc = {crc[6:0], 1'b0} ^ SCDA_CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc;
  endfunction

  function automatic logic scda_addr_valid(input logic [7:0] a);
    unique case (a)
      SCDA_A_SERIAL0, SCDA_A_SERIAL1, SCDA_A_SERIAL2, SCDA_A_SERIAL3,
      SCDA_A_DEFL, SCDA_A_RSVD05, SCDA_A_FCFG, SCDA_A_PART,
      SCDA_A_DEVICE_CONTROL, SCDA_A_DEVICE_CONFIG, SCDA_A_AXIS, SCDA_A_ARM,
      SCDA_A_THR_POS, SCDA_A_THR_NEG, SCDA_A_STATE, SCDA_A_COUNT,
      SCDA_A_OFFSET_CORRECTION_VALUE, SCDA_A_RSVD1C, SCDA_A_RSVD1D: return 1'b1;
      default:                                       return 1'b0;
    endcase
  endfunction

  typedef enum logic [1:0] {SCDA_RS_IDLE, SCDA_RS_GOT1, SCDA_RS_GOT2} scda_rs_e;

  // OTP shadow
  scda_otp_s   shadow;
  logic        loaded;
  // writable block
  logic [5:0]  device_control;
  logic [7:0]  device_config;
  logic [7:0]  axis;
  logic [7:0]  arm;
  logic [7:0]  thr_pos;
  logic [7:0]  thr_neg;
  logic        lock;
  // check state
  logic [7:0]  wr_crc_ref;
  logic        wr_crc_armed;
  scda_rs_e    rs_state;
  scda_rs_e    next_rs_state;
  logic        next_soft_reset;

  logic        acc_ok;
  logic        wr_ok;
  logic        device_control_wr;
  logic [7:0]  rd_data;
  logic [7:0]  otp_crc_now;
  logic [7:0]  wr_crc_now;

  assign acc_ok    = req_i && scda_addr_valid(req_data_i.addr);
  assign wr_ok     = acc_ok && req_data_i.write && !lock;
  assign device_control_wr = acc_ok && req_data_i.write && (req_data_i.addr == SCDA_A_DEVICE_CONTROL);

  // serial id and factory values hash into the OTP check only
  assign otp_crc_now = scda_crc8({shadow.serial, shadow.deflection,
                                  shadow.self_test_magnitude, 7'h00, shadow.part, 8'h00});
  assign wr_crc_now  = scda_crc8({2'b00, device_control, device_config, axis, arm, thr_pos, thr_neg, 16'h0000});

  // read mux; device control reset bits always read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (req_data_i.addr)
      SCDA_A_SERIAL0: rd_data = shadow.serial[7:0];
      SCDA_A_SERIAL1: rd_data = shadow.serial[15:8];
      SCDA_A_SERIAL2: rd_data = shadow.serial[23:16];
      SCDA_A_SERIAL3: rd_data = shadow.serial[31:24];
      SCDA_A_DEFL:    rd_data = shadow.deflection;
      SCDA_A_FCFG:    rd_data = {shadow.self_test_magnitude, 7'h00};
      SCDA_A_PART:    rd_data = shadow.part;
      SCDA_A_DEVICE_CONTROL:  rd_data = {2'b00, device_control};
      SCDA_A_DEVICE_CONFIG:  rd_data = device_config;
      SCDA_A_AXIS:    rd_data = axis;
      SCDA_A_ARM:     rd_data = arm;
      SCDA_A_THR_POS: rd_data = thr_pos;
      SCDA_A_THR_NEG: rd_data = thr_neg;
      SCDA_A_STATE:   rd_data = stat_i.state_flags;
      SCDA_A_COUNT:   rd_data = stat_i.frame_count;
      SCDA_A_OFFSET_CORRECTION_VALUE: rd_data = stat_i.offset_corr;
      default:        rd_data = 8'h00;
    endcase
  end

  // response, one cycle after the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o   <= 1'b0;
      rsp_data_o    <= SCDA_REG_RESET;
      rsp_invalid_o <= 1'b0;
    end else begin
      rsp_valid_o   <= req_i;
      rsp_data_o    <= acc_ok ? rd_data : 8'h00;
      rsp_invalid_o <= req_i && !acc_ok;
    end
  end

  // OTP shadow is loaded once after reset release and never written by the host
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow <= '0;
      loaded <= 1'b0;
    end else if (!loaded) begin
      shadow <= otp_i;
      loaded <= 1'b1;
    end
  end

  // device reset sequence on the two upper control bits
  always_comb begin
    next_rs_state   = SCDA_RS_IDLE;
    next_soft_reset = 1'b0;
    if (device_control_wr) begin
      if (req_data_i.wdata[7:6] == SCDA_RES_STEP1) begin
        next_rs_state = SCDA_RS_GOT1;
      end else if (req_data_i.wdata[7:6] == SCDA_RES_STEP2 && rs_state == SCDA_RS_GOT1) begin
        next_rs_state = SCDA_RS_GOT2;
      end else if (req_data_i.wdata[7:6] == SCDA_RES_STEP3 && rs_state == SCDA_RS_GOT2) begin
        next_soft_reset = 1'b1;
      end
    end else if (!req_i) begin
      next_rs_state = rs_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs_state     <= SCDA_RS_IDLE;
      soft_reset_o <= 1'b0;
    end else begin
      rs_state     <= soft_reset_o ? SCDA_RS_IDLE : next_rs_state;
      soft_reset_o <= next_soft_reset;
    end
  end

  // device control lower bits, writable only before the lock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_control <= 6'h00;
    end else if (soft_reset_o) begin
      device_control <= 6'h00;
    end else if (wr_ok && req_data_i.addr == SCDA_A_DEVICE_CONTROL) begin
      device_control[SCDA_OFFCFG_BIT] <= req_data_i.wdata[SCDA_OFFCFG_BIT];
      device_control[2:0]             <= req_data_i.wdata[2:0];
      if (req_data_i.wdata[SCDA_OFFCFG_BIT]) begin
        device_control[5:4] <= req_data_i.wdata[5:4];
      end
    end
  end

  // configuration bytes, frozen by the lock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_config  <= SCDA_REG_RESET;
      axis    <= SCDA_REG_RESET;
      arm     <= SCDA_REG_RESET;
      thr_pos <= SCDA_REG_RESET;
      thr_neg <= SCDA_REG_RESET;
    end else if (soft_reset_o) begin
      device_config  <= SCDA_REG_RESET;
      axis    <= SCDA_REG_RESET;
      arm     <= SCDA_REG_RESET;
      thr_pos <= SCDA_REG_RESET;
      thr_neg <= SCDA_REG_RESET;
    end else if (wr_ok) begin
      unique case (req_data_i.addr)
        SCDA_A_DEVICE_CONFIG:  device_config  <= req_data_i.wdata;
        SCDA_A_AXIS:    axis    <= req_data_i.wdata;
        SCDA_A_ARM:     arm     <= req_data_i.wdata;
        SCDA_A_THR_POS: thr_pos <= req_data_i.wdata;
        SCDA_A_THR_NEG: thr_neg <= req_data_i.wdata;
        default:        ;
      endcase
    end
  end

  // the lock follows its stored bit; only a device reset clears it
  assign lock = device_config[SCDA_LOCK_BIT];

  // writable block check: reference taken the cycle after locking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_crc_ref   <= 8'h00;
      wr_crc_armed <= 1'b0;
    end else if (soft_reset_o) begin
      wr_crc_armed <= 1'b0;
    end else if (lock && !wr_crc_armed) begin
      wr_crc_ref   <= wr_crc_now;
      wr_crc_armed <= 1'b1;
    end
  end

  // sticky fault flags; a detected fault wins over the reset-sequence clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_crc_err_o <= 1'b0;
      wr_crc_err_o  <= 1'b0;
    end else begin
      otp_crc_err_o <= (loaded && otp_crc_now != shadow.crc) ||
                       (otp_crc_err_o && !soft_reset_o);
      wr_crc_err_o  <= (wr_crc_armed && wr_crc_now != wr_crc_ref) ||
                       (wr_crc_err_o && !soft_reset_o);
    end
  end

  // configuration seen by the sensor path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_o            <= '0;
      init_done_lock_o <= 1'b0;
    end else begin
      cfg_o.device_control     <= device_control;
      cfg_o.device_config     <= device_config;
      cfg_o.axis       <= axis;
      cfg_o.arm        <= arm;
      cfg_o.thr_pos    <= thr_pos;
      cfg_o.thr_neg    <= thr_neg;
      cfg_o.ofmon_on   <= device_config[SCDA_OFMON_BIT] || !device_config[SCDA_OC_BIT];
      cfg_o.st_on      <= axis[SCDA_ST_BIT] && !lock;
      cfg_o.oc_normal  <= lock;
      init_done_lock_o <= lock;
    end
  end

  default clocking scda_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_lock_sticky;
    lock && !soft_reset_o |=> lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

  property p_locked_stable;
    lock && !soft_reset_o |=> $stable({device_config, axis, arm, thr_pos, thr_neg, device_control});
  endproperty
  a_locked_stable: assert property (p_locked_stable) else $error("locked cfg moved");

  property p_invalid_answer;
    req_i && !scda_addr_valid(req_data_i.addr) |=> rsp_valid_o && rsp_invalid_o && rsp_data_o == 8'h00;
  endproperty
  a_invalid_answer: assert property (p_invalid_answer) else $error("no invalid answer");

  property p_invalid_nowrite;
    req_i && !scda_addr_valid(req_data_i.addr) && !soft_reset_o
      |=> $stable({device_config, axis, arm, thr_pos, thr_neg, device_control});
  endproperty
  a_invalid_nowrite: assert property (p_invalid_nowrite) else $error("invalid addr wrote");

  property p_otp_frozen;
    loaded |=> $stable(shadow) [*3];
  endproperty
  a_otp_frozen: assert property (p_otp_frozen) else $error("otp shadow changed");

  property p_fcfg_zero;
    req_i && req_data_i.addr == SCDA_A_FCFG
      |=> rsp_data_o[6:0] == 7'h00 && rsp_data_o[SCDA_SELF_TEST_MAGNITUDE_BIT] == shadow.self_test_magnitude;
  endproperty
  a_fcfg_zero: assert property (p_fcfg_zero) else $error("factory cfg read wrong");

  property p_serial_lsb;
    req_i && req_data_i.addr == SCDA_A_SERIAL1
      |=> rsp_data_o[SCDA_UNIT_IDX_W-8-1:0] == shadow.serial[SCDA_UNIT_IDX_W-1:8];
  endproperty
  a_serial_lsb: assert property (p_serial_lsb) else $error("serial byte order wrong");

  property p_defl_read;
    req_i && req_data_i.addr == SCDA_A_DEFL |=> rsp_data_o == shadow.deflection;
  endproperty
  a_defl_read: assert property (p_defl_read) else $error("deflection read wrong");

  property p_otp_crc;
    loaded && otp_crc_now != shadow.crc |=> otp_crc_err_o ##1 otp_crc_err_o || $past(soft_reset_o);
  endproperty
  a_otp_crc: assert property (p_otp_crc) else $error("otp fault not flagged");

  property p_wr_crc;
    wr_crc_armed && wr_crc_now != wr_crc_ref |=> wr_crc_err_o;
  endproperty
  a_wr_crc: assert property (p_wr_crc) else $error("writable fault not flagged");

  property p_reset_seq;
    device_control_wr && req_data_i.wdata[7:6] == SCDA_RES_STEP3 && rs_state == SCDA_RS_GOT2
      |=> soft_reset_o ##1 !soft_reset_o && rs_state == SCDA_RS_IDLE;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence missed");

endmodule

`default_nettype wire

// ===== scda_pkg.sv
// scda_pkg: constants, field layouts and carriers of the sensor configuration data array.
// assumes one 40 MHz clock domain shared by the frame decoder, the OTP fuse reader and the array.
package scda_pkg;

  // register offsets
  localparam logic [7:0] SCDA_A_SERIAL0   = 8'h00;
  localparam logic [7:0] SCDA_A_SERIAL1   = 8'h01;
  localparam logic [7:0] SCDA_A_SERIAL2   = 8'h02;
  localparam logic [7:0] SCDA_A_SERIAL3   = 8'h03;
  localparam logic [7:0] SCDA_A_DEFL      = 8'h04;
  localparam logic [7:0] SCDA_A_RSVD05    = 8'h05;
  localparam logic [7:0] SCDA_A_FCFG      = 8'h06;
  localparam logic [7:0] SCDA_A_PART      = 8'h08;
  localparam logic [7:0] SCDA_A_DEVICE_CONTROL    = 8'h0A;
  localparam logic [7:0] SCDA_A_DEVICE_CONFIG    = 8'h0B;
  localparam logic [7:0] SCDA_A_AXIS      = 8'h0C;
  localparam logic [7:0] SCDA_A_ARM       = 8'h0E;
  localparam logic [7:0] SCDA_A_THR_POS   = 8'h10;
  localparam logic [7:0] SCDA_A_THR_NEG   = 8'h12;
  localparam logic [7:0] SCDA_A_STATE     = 8'h14;
  localparam logic [7:0] SCDA_A_COUNT     = 8'h15;
  localparam logic [7:0] SCDA_A_OFFSET_CORRECTION_VALUE   = 8'h16;
  localparam logic [7:0] SCDA_A_RSVD1C    = 8'h1C;
  localparam logic [7:0] SCDA_A_RSVD1D    = 8'h1D;

  // field positions
  localparam int         SCDA_UNIT_IDX_W  = 13;
  localparam int         SCDA_SELF_TEST_MAGNITUDE_BIT   = 7;
  localparam int         SCDA_OC_BIT      = 7;
  localparam int         SCDA_LOCK_BIT    = 5;
  localparam int         SCDA_OFMON_BIT   = 3;
  localparam int         SCDA_ST_BIT      = 7;
  localparam int         SCDA_OFFCFG_BIT  = 3;
  localparam logic [1:0] SCDA_RES_STEP1   = 2'h0;
  localparam logic [1:0] SCDA_RES_STEP2   = 2'h3;
  localparam logic [1:0] SCDA_RES_STEP3   = 2'h1;

  // reset values and check polynomial
  localparam logic [7:0] SCDA_REG_RESET   = 8'h00;
  localparam logic [7:0] SCDA_CRC_POLY    = 8'h2F;
  localparam logic [7:0] SCDA_CRC_SEED    = 8'hFF;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scda_req_s;

  typedef struct packed {
    logic [31:0] serial;
    logic [7:0]  deflection;
    logic        self_test_magnitude;
    logic [7:0]  part;
    logic [7:0]  crc;
  } scda_otp_s;

  typedef struct packed {
    logic [7:0] state_flags;
    logic [7:0] frame_count;
    logic [7:0] offset_corr;
  } scda_stat_s;

  typedef struct packed {
    logic [5:0] device_control;
    logic [7:0] device_config;
    logic [7:0] axis;
    logic [7:0] arm;
    logic [7:0] thr_pos;
    logic [7:0] thr_neg;
    logic       ofmon_on;
    logic       st_on;
    logic       oc_normal;
  } scda_cfg_s;

endpackage

// ===== scda_host_model.sv
// scda_host_model: behavioural host that issues register accesses to the array.
// assumes the array answers one cycle after a request; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module scda_host_model
  import scda_pkg::*;
(
  // clock
  input  wire logic      clk_i,
  // request side
  output var  logic      req_o,
  output var  scda_req_s req_data_o,
  // answer side
  input  wire logic      rsp_valid_i,
  input  wire logic [7:0] rsp_data_i,
  input  wire logic      rsp_invalid_i
);
  initial begin
    req_o      = 1'b0;
    req_data_o = '0;
  end

  // one access; an answer that never comes returns unknowns
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic inv);
    int n;
    n = 0;
    @(negedge clk_i);
    req_o      = 1'b1;
    req_data_o = '{write: w, addr: a, wdata: d};
    @(negedge clk_i);
    req_o      = 1'b0;
    // released lines must not keep showing the last request
    req_data_o = scda_req_s'(~req_data_o);
    while (rsp_valid_i !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    rd  = (n < 8) ? rsp_data_i : 8'hXX;
    inv = (n < 8) ? rsp_invalid_i : 1'bX;
  endtask
endmodule
`default_nettype wire

// ===== sensor_config_data_array_tb_top.sv
// sensor_config_data_array_tb_top: self-checking bench for the register array.
// assumes scda_pkg, scda_array and scda_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module sensor_config_data_array_tb_top
  import scda_pkg::*;
;
  logic       clk_i;
  logic       rst_n_i;
  logic       req_i;
  scda_req_s  req_data_i;
  logic       rsp_valid_o;
  logic [7:0] rsp_data_o;
  logic       rsp_invalid_o;
  scda_otp_s  otp;
  scda_stat_s stat;
  scda_cfg_s  cfg_o;
  logic       init_done_lock_o;
  logic       otp_crc_err_o;
  logic       wr_crc_err_o;
  logic       soft_reset_o;
  logic [7:0] rd;
  logic       inv;
  int         n_errors;
  int         compares;
  int         sr_cnt = 0;

  scda_array DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .req_data_i(req_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_invalid_o(rsp_invalid_o),
    .otp_i(otp), .stat_i(stat), .cfg_o(cfg_o), .init_done_lock_o(init_done_lock_o),
    .otp_crc_err_o(otp_crc_err_o), .wr_crc_err_o(wr_crc_err_o), .soft_reset_o(soft_reset_o));

  scda_host_model host (.clk_i(clk_i), .req_o(req_i), .req_data_o(req_data_i),
    .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o), .rsp_invalid_i(rsp_invalid_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (soft_reset_o === 1'b1) sr_cnt <= sr_cnt + 1;

  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = SCDA_CRC_SEED;
    for (int i = 63; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? SCDA_CRC_POLY : 8'h00);
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    host.access(w, a, d, rd, inv);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask

  // factory bytes read back in order, then writes to them must be ignored
  task automatic t_otp_read();
    logic [31:0] ser;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 8'(i), 8'h00);
      ser[8*i +: 8] = rd;
      check(rd, otp.serial[8*i +: 8]);
    end
    check(ser[12:0], otp.serial[12:0]);
    acc(1'b0, SCDA_A_DEFL, 8'h00);
    check(rd, 8'hFF);
    acc(1'b0, SCDA_A_FCFG, 8'h00);
    check(rd, {otp.self_test_magnitude, 7'h00});
    acc(1'b1, SCDA_A_DEFL, 8'h00);
    acc(1'b1, SCDA_A_FCFG, 8'h7F);
    acc(1'b1, SCDA_A_SERIAL0, 8'h00);
    acc(1'b0, SCDA_A_DEFL, 8'h00);
    check(rd, 8'hFF);
    acc(1'b0, SCDA_A_FCFG, 8'h00);
    check(rd, {otp.self_test_magnitude, 7'h00});
    acc(1'b0, SCDA_A_SERIAL0, 8'h00);
    check(rd, otp.serial[7:0]);
    acc(1'b0, SCDA_A_RSVD05, 8'h00);
    check(inv, 1'b0);
  endtask

  // holes in the map answer invalid and must not alias onto the lock
  task automatic t_invalid();
    logic [55:0] bad;
    bad = 56'h07090D0F111317;
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, bad[8*i +: 8], 8'h20);
      check(inv, 1'b1);
      check(rd, 8'h00);
    end
    check(init_done_lock_o, 1'b0);
  endtask

  // mapped factory and live registers answer; control bits and derived enables
  task automatic t_cfg_path();
    acc(1'b0, SCDA_A_PART, 8'h00);
    check(rd, otp.part);
    acc(1'b0, SCDA_A_STATE, 8'h00);
    check(rd, stat.state_flags);
    acc(1'b0, SCDA_A_COUNT, 8'h00);
    check(rd, stat.frame_count);
    acc(1'b0, SCDA_A_OFFSET_CORRECTION_VALUE, 8'h00);
    check({inv, rd}, {1'b0, stat.offset_corr});
    @(negedge clk_i);
    check({rsp_valid_o, rsp_invalid_o}, 2'b00);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h1D);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h05);
    acc(1'b0, SCDA_A_DEVICE_CONTROL, 8'h00);
    check(rd, 8'h15);
    acc(1'b1, SCDA_A_DEVICE_CONFIG, 8'h80);
    acc(1'b1, SCDA_A_AXIS, 8'h80);
    repeat (2) @(negedge clk_i);
    check({cfg_o.device_control, cfg_o.ofmon_on, cfg_o.st_on, cfg_o.oc_normal}, {6'h15, 3'b010});
  endtask

  task automatic t_lock();
    acc(1'b1, SCDA_A_AXIS, 8'h83);
    repeat (2) @(negedge clk_i);
    check(cfg_o.axis, 8'h83);
    acc(1'b1, SCDA_A_DEVICE_CONFIG, 8'h20);
    repeat (2) @(negedge clk_i);
    check(init_done_lock_o, 1'b1);
    check({cfg_o.ofmon_on, cfg_o.st_on, cfg_o.oc_normal}, 3'b101);
    acc(1'b1, SCDA_A_AXIS, 8'h0C);
    acc(1'b0, SCDA_A_AXIS, 8'h00);
    check(rd, 8'h83);
    acc(1'b1, SCDA_A_DEVICE_CONFIG, 8'h00);
    acc(1'b0, SCDA_A_DEVICE_CONFIG, 8'h00);
    check(rd, 8'h20);
    repeat (4) @(negedge clk_i);
    check(wr_crc_err_o, 1'b0);
  endtask

  // an interrupted sequence does nothing, a clean one clears the lock
  task automatic t_reset_seq();
    int base;
    base = sr_cnt;
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h00);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'hC0);
    acc(1'b0, SCDA_A_DEVICE_CONTROL, 8'h00);
    check(rd[7:6], 2'h0);
    check(rd[5:0], 6'h15);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h40);
    repeat (3) @(negedge clk_i);
    check(sr_cnt - base, 0);
    check(init_done_lock_o, 1'b1);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h00);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'hC0);
    acc(1'b1, SCDA_A_DEVICE_CONTROL, 8'h40);
    repeat (3) @(negedge clk_i);
    check(sr_cnt - base, 1);
    check(init_done_lock_o, 1'b0);
    acc(1'b0, SCDA_A_AXIS, 8'h00);
    check(rd, SCDA_REG_RESET);
    acc(1'b0, SCDA_A_DEVICE_CONTROL, 8'h00);
    check(rd, 8'h00);
  endtask

  // a flipped serial bit with the stored check value kept must be caught
  task automatic t_otp_crc();
    otp.serial[20] = ~otp.serial[20];
    do_reset();
    repeat (4) @(negedge clk_i);
    check(otp_crc_err_o, 1'b1);
    check(wr_crc_err_o, 1'b0);
    otp.serial[20] = ~otp.serial[20];
    do_reset();
    repeat (4) @(negedge clk_i);
    check(otp_crc_err_o, 1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end

  initial begin
    rst_n_i  = 1'b0;
    n_errors = 0;
    compares = 0;
    stat     = '{state_flags: 8'h12, frame_count: 8'h34, offset_corr: 8'h56};
    otp      = '{serial: 32'hA5C31E7B, deflection: 8'hFF, self_test_magnitude: 1'b1, part: 8'h5A,
                 crc: 8'h00};
    otp.crc  = crc8({otp.serial, otp.deflection, otp.self_test_magnitude, 7'h00, otp.part, 8'h00});
    do_reset();
    repeat (2) @(negedge clk_i);
    check(otp_crc_err_o, 1'b0);
    t_otp_read();
    t_invalid();
    t_cfg_path();
    t_lock();
    t_reset_seq();
    t_otp_crc();
    end_of_test();
  end
endmodule
`default_nettype wire
